//--- stc_timer.sv
// Sixteen-bit timer/counter with prescaler, external clock and overflow interrupt.
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module stc_timer (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       sleep,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            irq,
	input  wire logic       ext_count_clock_pin,
	input  wire logic       osc_in_pin,
	input  wire logic       port_c_dir_in_n,
	output logic            osc_run,
	output logic            osc_in_oe_n,
	output logic            osc_amp_oe_n
);
	// ************************************************************
	// Registers
	// ************************************************************
	stc_pkg::stc_bus_s  bus;
	stc_pkg::stc_ctrl_s ctrl_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic        flag_r;
	logic        enable_r;
	logic [1:0]  instr_cnt_r;
	logic        instr_tick;
	logic [2:0]  ext_sync_r;
	logic        ext_prev_r;
	logic        ext_rise;
	logic [2:0]  pre_cnt_r;
	logic        in_tick;
	logic        cnt_tick;
	logic        wrap;
	logic        ext_raw_prev_r;
	logic        ext_raw_rise;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// ************************************************************
	// Bus decode
	// ************************************************************
	// Write hits are matched in one place so that no path can miss an offset.
	function automatic logic wr_hit(input stc_pkg::stc_bus_s b, input logic [7:0] ofs);
		wr_hit = b.wr && (b.addr == ofs);
	endfunction

	// ************************************************************
	// Control register
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_r <= stc_ctrl_s_reset();
		end else if (wr_hit(bus, stc_pkg::CTRL_OFS)) begin
			ctrl_r <= bus.wdata[5:0];
		end
	end

	function automatic stc_pkg::stc_ctrl_s stc_ctrl_s_reset();
		stc_ctrl_s_reset = stc_pkg::CTRL_RESET[5:0];
	endfunction

	// ************************************************************
	// Clock sources
	// ************************************************************
	// One instruction cycle is four core clocks.
	always_ff @(posedge clk) begin
		if (reset) begin
			instr_cnt_r <= 2'h0;
		end else begin
			instr_cnt_r <= (instr_cnt_r == stc_pkg::INSTR_LAST) ? 2'h0 : instr_cnt_r + 2'h1;
		end
	end
	assign instr_tick = (instr_cnt_r == stc_pkg::INSTR_LAST);

	// The source pin is the oscillator input when enabled, else the count pin.
	always_ff @(posedge clk) begin
		if (reset) begin
			ext_sync_r     <= 3'h0;
			ext_prev_r     <= 1'b0;
			ext_raw_prev_r <= 1'b0;
		end else begin
			ext_sync_r <= {ext_sync_r[1:0],
				ctrl_r.osc_enable ? osc_in_pin : ext_count_clock_pin};
			if (ext_sync_r[2] == ext_sync_r[1]) begin
				ext_prev_r <= ext_sync_r[2];
			end
			ext_raw_prev_r <= ext_sync_r[1];
		end
	end
	// Full agreement is the synchronised edge; the unsynchronised path skips the
	// agreement filter, trading glitch immunity for one cycle less latency.
	assign ext_rise     = (ext_sync_r[2] == ext_sync_r[1]) && ext_sync_r[2] && !ext_prev_r;
	assign ext_raw_rise = ext_sync_r[1] && !ext_raw_prev_r;

	always_comb begin
		if (!ctrl_r.clock_source_sel) begin
			in_tick = instr_tick && !sleep;
		end else if (ctrl_r.ext_sync_n) begin
			in_tick = ext_raw_rise;
		end else begin
			in_tick = ext_rise && !sleep;
		end
	end

	// ************************************************************
	// Prescaler
	// ************************************************************
	function automatic logic [2:0] pre_mask(input logic [1:0] code);
		unique case (code)
			2'h3: pre_mask = 3'h7;
			2'h2: pre_mask = 3'h3;
			2'h1: pre_mask = 3'h1;
			2'h0: pre_mask = 3'h0;
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (reset || !ctrl_r.count_run) begin
			pre_cnt_r <= 3'h0;
		end else if (in_tick) begin
			pre_cnt_r <= (pre_cnt_r & pre_mask(ctrl_r.prescale)) == pre_mask(ctrl_r.prescale)
				? 3'h0 : pre_cnt_r + 3'h1;
		end
	end
	assign cnt_tick = ctrl_r.count_run && in_tick
		&& ((pre_cnt_r & pre_mask(ctrl_r.prescale)) == pre_mask(ctrl_r.prescale));

	// ************************************************************
	// Counter
	// ************************************************************
	assign wrap = cnt_tick && count_r == stc_pkg::COUNT_FULL;

	always_comb begin
		count_nxt = count_r;
		if (wr_hit(bus, stc_pkg::COUNT_LO_OFS)) begin
			count_nxt[7:0] = bus.wdata;
		end else if (wr_hit(bus, stc_pkg::COUNT_HI_OFS)) begin
			count_nxt[15:8] = bus.wdata;
		end else if (cnt_tick) begin
			count_nxt = count_r + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_r <= stc_pkg::COUNT_RESET;
		end else begin
			count_r <= count_nxt;
		end
	end

	// ************************************************************
	// Interrupt
	// ************************************************************
	// A wrap in the cycle of a clearing write still leaves the flag set.
	always_ff @(posedge clk) begin
		if (reset) begin
			flag_r <= 1'b0;
		end else if (wrap) begin
			flag_r <= 1'b1;
		end else if (wr_hit(bus, stc_pkg::FLAG_OFS) && bus.wdata[stc_pkg::OVF_BIT]) begin
			flag_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			enable_r <= 1'b0;
		end else if (wr_hit(bus, stc_pkg::ENABLE_OFS)) begin
			enable_r <= bus.wdata[stc_pkg::OVF_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= (flag_r || wrap) && enable_r;
		end
	end

	// ************************************************************
	// Oscillator and pins
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_run      <= 1'b0;
			osc_in_oe_n  <= 1'b1;
			osc_amp_oe_n <= 1'b1;
		end else begin
			osc_run      <= ctrl_r.osc_enable;
			osc_in_oe_n  <= ctrl_r.osc_enable | port_c_dir_in_n;
			osc_amp_oe_n <= ctrl_r.osc_enable | port_c_dir_in_n;
		end
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				stc_pkg::CTRL_OFS:     rdata <= {2'b00, ctrl_r};
				stc_pkg::COUNT_LO_OFS: rdata <= count_r[7:0];
				stc_pkg::COUNT_HI_OFS: rdata <= count_r[15:8];
				stc_pkg::FLAG_OFS:     rdata <= {7'h00, flag_r};
				stc_pkg::ENABLE_OFS:   rdata <= {7'h00, enable_r};
				default:               rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	wrap_sets_flag_a: assert property (@(posedge clk) disable iff (reset)
		wrap |=> flag_r) else $error("Wrap did not set the flag.");
	wrap_to_zero_a: assert property (@(posedge clk) disable iff (reset)
		wrap && !bus.wr |=> count_r == 16'h0000) else $error("Count did not wrap to zero.");
	stop_holds_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl_r.count_run && !bus.wr |=> $stable(count_r)) else $error("Stopped counter moved.");
	irq_masked_a: assert property (@(posedge clk) disable iff (reset)
		!enable_r |=> !irq) else $error("Masked interrupt seen.");
	irq_follows_a: assert property (@(posedge clk) disable iff (reset)
		flag_r && enable_r |=> irq) else $error("Interrupt missing.");
	ctrl_top_zero_a: assert property (@(posedge clk) disable iff (reset)
		$past(bus.rd) && $past(bus.addr) == 8'h10 |-> rdata[7:6] == 2'b00)
		else $error("Unimplemented bits read nonzero.");
	div_eight_a: assert property (@(posedge clk) disable iff (reset)
		cnt_tick && ctrl_r.prescale == 2'h3 |-> pre_cnt_r == 3'h7) else $error("Bad divide by 8.");
	div_one_a: assert property (@(posedge clk) disable iff (reset)
		in_tick && ctrl_r.count_run && ctrl_r.prescale == 2'h0 |-> cnt_tick)
		else $error("Undivided tick lost.");
	internal_rate_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl_r.clock_source_sel && in_tick |=> !in_tick [*3]) else $error("Internal rate wrong.");
	pins_input_a: assert property (@(posedge clk) disable iff (reset)
		ctrl_r.osc_enable |=> osc_in_oe_n && osc_amp_oe_n) else $error("Oscillator pin driven.");
	osc_follow_a: assert property (@(posedge clk) disable iff (reset)
		ctrl_r.osc_enable |=> osc_run) else $error("Oscillator not running.");

	// ************************************************************
	// Counter checks
	// ************************************************************
	count_step_a: assert property (@(posedge clk) disable iff (reset)
		cnt_tick && !bus.wr |=> count_r == 16'($past(count_r) + 16'h0001))
		else $error("Count did not step by one.");
	no_early_wrap_a: assert property (@(posedge clk) disable iff (reset)
		cnt_tick && !bus.wr && count_r != 16'hFFFF |=> count_r != 16'h0000)
		else $error("Count wrapped early.");
	low_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_hit(bus, stc_pkg::COUNT_LO_OFS) |=> count_r[7:0] == $past(bus.wdata))
		else $error("Low byte write lost.");
	high_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_hit(bus, stc_pkg::COUNT_HI_OFS) |=> count_r[15:8] == $past(bus.wdata))
		else $error("High byte write lost.");
	stop_no_tick_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl_r.count_run |-> !cnt_tick)
		else $error("Stopped counter ticked.");
	stop_clears_pre_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl_r.count_run |=> pre_cnt_r == 3'h0)
		else $error("Prescaler kept its count.");
	div_two_a: assert property (@(posedge clk) disable iff (reset)
		cnt_tick && ctrl_r.prescale == 2'h1 |-> pre_cnt_r[0])
		else $error("Bad divide by 2.");
	div_four_a: assert property (@(posedge clk) disable iff (reset)
		cnt_tick && ctrl_r.prescale == 2'h2 |-> pre_cnt_r[1:0] == 2'h3)
		else $error("Bad divide by 4.");

	// ************************************************************
	// Interrupt checks
	// ************************************************************
	// A wrap outranks a clearing write, so the clear check leaves it out.
	flag_holds_a: assert property (@(posedge clk) disable iff (reset)
		flag_r && !wr_hit(bus, stc_pkg::FLAG_OFS) |=> flag_r)
		else $error("Flag dropped by itself.");
	flag_clear_a: assert property (@(posedge clk) disable iff (reset)
		wr_hit(bus, stc_pkg::FLAG_OFS) && bus.wdata[0] && !wrap |=> !flag_r)
		else $error("Flag not cleared.");
	irq_needs_flag_a: assert property (@(posedge clk) disable iff (reset)
		!flag_r && !wrap |=> !irq)
		else $error("Interrupt without flag.");
	irq_on_wrap_a: assert property (@(posedge clk) disable iff (reset)
		wrap && enable_r |=> irq)
		else $error("Wrap gave no interrupt.");
	enable_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_hit(bus, stc_pkg::ENABLE_OFS) |=> enable_r == $past(bus.wdata[0]))
		else $error("Enable write lost.");

	// ************************************************************
	// Control and clock checks
	// ************************************************************
	ctrl_write_a: assert property (@(posedge clk) disable iff (reset)
		wr_hit(bus, stc_pkg::CTRL_OFS) |=> 6'(ctrl_r) == $past(bus.wdata[5:0]))
		else $error("Control write lost.");
	ctrl_read_a: assert property (@(posedge clk) disable iff (reset)
		$past(bus.rd) && $past(bus.addr) == 8'h10 |-> rdata[5:0] == 6'($past(ctrl_r)))
		else $error("Control read wrong.");
	sleep_stops_a: assert property (@(posedge clk) disable iff (reset)
		sleep && !(ctrl_r.clock_source_sel && ctrl_r.ext_sync_n) |-> !in_tick)
		else $error("Tick during sleep.");
	unsync_runs_a: assert property (@(posedge clk) disable iff (reset)
		ctrl_r.clock_source_sel && ctrl_r.ext_sync_n && ext_raw_rise |-> in_tick)
		else $error("Unsynchronised edge lost.");
	sync_ignored_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl_r.clock_source_sel |-> in_tick == (instr_tick && !sleep))
		else $error("Sync bit changed timer mode.");
	ext_edge_a: assert property (@(posedge clk) disable iff (reset)
		ctrl_r.clock_source_sel && !ctrl_r.ext_sync_n && in_tick |-> ext_sync_r[2])
		else $error("External tick without high input.");
	osc_off_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl_r.osc_enable |=> !osc_run)
		else $error("Oscillator left running.");
	pins_driven_a: assert property (@(posedge clk) disable iff (reset)
		!ctrl_r.osc_enable && !port_c_dir_in_n |=> !osc_in_oe_n && !osc_amp_oe_n)
		else $error("Output pins not driven.");
endmodule
`default_nettype wire

//--- stc_pkg.sv
// Package of constants and types for the sixteen-bit timer/counter.
`default_nettype none
package stc_pkg;
	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] CTRL_OFS      = 8'h10;
	localparam logic [7:0] COUNT_LO_OFS  = 8'h0E;
	localparam logic [7:0] COUNT_HI_OFS  = 8'h0F;
	localparam logic [7:0] FLAG_OFS      = 8'h0C;
	localparam logic [7:0] ENABLE_OFS    = 8'h8C;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [7:0] CTRL_IMPL     = 8'h3F;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] COUNT_FULL   = 16'hFFFF;
	// ************************************************************
	// Control field positions
	// ************************************************************
	localparam int RUN_BIT       = 0;
	localparam int SRC_BIT       = 1;
	localparam int SYNC_N_BIT    = 2;
	localparam int OSC_EN_BIT    = 3;
	localparam int PRESCALE_LO   = 4;
	localparam int PRESCALE_HI   = 5;
	localparam int OVF_BIT       = 0;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int INSTR_PERIOD_PS = 20000;
	localparam int INSTR_CYCLES    = (INSTR_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_CYCLES - 1);
	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} stc_bus_s;
	typedef struct packed {
		logic [1:0] prescale;
		logic       osc_enable;
		logic       ext_sync_n;
		logic       clock_source_sel;
		logic       count_run;
	} stc_ctrl_s;
endpackage
`default_nettype wire

//--- stc_ext_src.sv
// Model of the crystal and clock source on the counter pins.
`timescale 1ns/100ps
`default_nettype none
module stc_ext_src (
	input  wire logic       osc_run,
	input  wire logic       ext_go,
	input  wire logic [7:0] ext_pulses,
	output logic            ext_count_clock_pin,
	output logic            osc_in_pin
);
	initial begin
		ext_count_clock_pin = 1'b0;
		osc_in_pin = 1'b0;
	end
	// Each request gives a burst of whole pulses; the pin stands low between bursts.
	always @(posedge ext_go) begin
		repeat (ext_pulses) begin
			#20 ext_count_clock_pin = 1'b1;
			#20 ext_count_clock_pin = 1'b0;
		end
	end
	// The crystal needs time to start and is still while disabled, sleep or not.
	always begin
		wait (osc_run === 1'b1);
		#300;
		while (osc_run === 1'b1) begin
			#50 osc_in_pin = 1'b1;
			#50 osc_in_pin = 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- stc_timer_tb.sv
// Self-checking testbench of the sixteen-bit timer/counter.
`timescale 1ns/100ps
`default_nettype none
module stc_timer_tb;
	logic       clk, reset, sleep, wr, rd, irq, ext_go, osc_run;
	logic [7:0] addr, wdata, rdata, ext_pulses, rv;
	logic       ext_pin, osc_pin, oe_in_n, oe_amp_n, dir_n;
	logic [15:0] c, d;
	int         error_cnt, tests_run;
	stc_timer dut (.clk(clk), .reset(reset), .sleep(sleep), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .ext_count_clock_pin(ext_pin),
		.osc_in_pin(osc_pin), .port_c_dir_in_n(dir_n), .osc_run(osc_run),
		.osc_in_oe_n(oe_in_n), .osc_amp_oe_n(oe_amp_n));
	stc_ext_src src (.osc_run(osc_run), .ext_go(ext_go), .ext_pulses(ext_pulses),
		.ext_count_clock_pin(ext_pin), .osc_in_pin(osc_pin));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rd_cnt(output logic [15:0] v);
		rd_reg(stc_pkg::COUNT_LO_OFS, v[7:0]);
		rd_reg(stc_pkg::COUNT_HI_OFS, v[15:8]);
	endtask
	task automatic clr_cnt;
		wr_reg(stc_pkg::COUNT_LO_OFS, 8'h00);
		wr_reg(stc_pkg::COUNT_HI_OFS, 8'h00);
	endtask
	task automatic t_reset;
		rd_reg(stc_pkg::CTRL_OFS, rv);
		check(rv, 8'h00);
		check({irq, osc_run, oe_in_n, oe_amp_n}, 4'h0);
		dir_n <= 1'b1;
		repeat (2) @(posedge clk);
		check({oe_in_n, oe_amp_n}, 2'h3);
		dir_n <= 1'b0;
		wr_reg(stc_pkg::CTRL_OFS, 8'hFF);
		rd_reg(stc_pkg::CTRL_OFS, rv);
		check(rv, 8'h3F);
		wr_reg(stc_pkg::CTRL_OFS, 8'h00);
		rd_reg(8'h55, rv);
		check(rv, 8'h00);
	endtask
	// Odd codes also set the sync bit, which must not matter in timer mode.
	task automatic t_timer;
		for (int i = 0; i < 4; i++) begin
			clr_cnt();
			wr_reg(stc_pkg::CTRL_OFS, 8'((i << 4) | ((i & 1) << 2) | 1));
			repeat (64 << i) @(posedge clk);
			wr_reg(stc_pkg::CTRL_OFS, 8'h00);
			rd_cnt(c);
			check(16'(c >= 16'h000F && c <= 16'h0011), 16'h0001);
			repeat (20) @(posedge clk);
			rd_cnt(d);
			check(d, c);
		end
	endtask
	task automatic t_ovf;
		wr_reg(stc_pkg::ENABLE_OFS, 8'h01);
		wr_reg(stc_pkg::COUNT_LO_OFS, 8'hFF);
		wr_reg(stc_pkg::COUNT_HI_OFS, 8'hFF);
		wr_reg(stc_pkg::CTRL_OFS, 8'h01);
		repeat (12) @(posedge clk);
		wr_reg(stc_pkg::CTRL_OFS, 8'h00);
		rd_reg(stc_pkg::FLAG_OFS, rv);
		check(rv[0], 1'b1);
		rd_cnt(c);
		check(16'(c < 16'h0008), 16'h0001);
		check(irq, 1'b1);
		wr_reg(stc_pkg::ENABLE_OFS, 8'h00);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		wr_reg(stc_pkg::ENABLE_OFS, 8'h01);
		wr_reg(stc_pkg::FLAG_OFS, 8'h01);
		rd_reg(stc_pkg::FLAG_OFS, rv);
		check({rv[0], irq}, 2'b00);
	endtask
	task automatic t_ext;
		for (int s = 0; s < 2; s++) begin
			clr_cnt();
			wr_reg(stc_pkg::CTRL_OFS, 8'(3 | (s << 2)));
			ext_pulses <= 8'h0A;
			ext_go <= 1'b1;
			@(posedge clk);
			ext_go <= 1'b0;
			repeat (100) @(posedge clk);
			wr_reg(stc_pkg::CTRL_OFS, 8'h00);
			rd_cnt(c);
			check(c, 16'h000A);
		end
	endtask
	task automatic t_osc;
		@(posedge clk);
		sleep <= 1'b1;
		wr_reg(stc_pkg::CTRL_OFS, 8'h0F);
		repeat (2) @(posedge clk);
		check({osc_run, oe_in_n, oe_amp_n}, 3'h7);
		repeat (100) @(posedge clk);
		clr_cnt();
		repeat (400) @(posedge clk);
		wr_reg(stc_pkg::CTRL_OFS, 8'h00);
		sleep <= 1'b0;
		rd_cnt(c);
		check(16'(c >= 16'h0011 && c <= 16'h0015), 16'h0001);
		check(osc_run, 1'b0);
		sleep <= 1'b1;
		wr_reg(stc_pkg::CTRL_OFS, 8'h0B);
		clr_cnt();
		repeat (300) @(posedge clk);
		wr_reg(stc_pkg::CTRL_OFS, 8'h00);
		sleep <= 1'b0;
		rd_cnt(c);
		check(c, 16'h0000);
	endtask
	task automatic close_out;
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
	initial begin
		error_cnt = 0;
		tests_run = 0;
		dir_n = 1'b0;
		{reset, sleep, wr, rd, ext_go} = 5'h10;
		{addr, wdata, ext_pulses} = 24'h000000;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_timer();
		t_ovf();
		t_ext();
		t_osc();
		close_out();
	end
endmodule
`default_nettype wire
